// File: rtl/eit_timer_top.sv
// Three 8-bit interval and event timers with port-3 direction control
// Summary of operation
// - Direction bit 0 drives pin, 1 releases
// - Direction resets all ones, top bits read 1
// - Direction register takes bit and byte writes
// - Timers independent, except the first can count the second timer's matches
// - Match clears counter and pulses interrupt together
// - Pin event counting only on timers two, three
// - Event mode counts pin edges, matches as usual
// - First timer offers six clock sources
// - Second timer offers six clock sources
// - Third timer offers six clock sources
// - Interval spans one to 256 count clocks
// - Enable clear zeroes counter, set starts counting
// - Mode zero selects stand-alone 8-bit counting
`timescale 1ns/1ps
module eit_timer_top #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_byte_wr,
  input wire logic cpu_bit_wr,
  input wire logic [2:0] cpu_bit_sel,
  input wire logic cpu_bit_val,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  input wire logic sub_clk,
  input wire logic [2:0] p3_in,
  output logic [2:0] p3_out,
  output logic [2:0] p3_oe,
  output logic [2:0] match_interrupt_request
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] apply_write(
    input logic [7:0] old,
    input logic byte_wr,
    input logic bit_wr,
    input logic [2:0] sel,
    input logic val,
    input logic [7:0] data,
    input logic [7:0] wmask
  );
    logic [7:0] res;
    res = old;
    if (byte_wr) begin
      res = data;
    end else if (bit_wr) begin
      res[sel] = val;
    end
    return res & wmask;
  endfunction

  function automatic logic div_tick(
    input logic [6:0] cnt,
    input logic [6:0] mask
  );
    return (cnt & mask) == mask;
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] port3_direction;
  logic [7:0] port3_latch;
  logic [7:0] mode0;
  logic [7:0] mode1;
  logic [7:0] mode2;
  logic [7:0] cmp0;
  logic [7:0] cmp1;
  logic [7:0] cmp2;
  logic [7:0] next_port3_direction;
  logic [7:0] next_port3_latch;
  logic [7:0] next_mode0;
  logic [7:0] next_mode1;
  logic [7:0] next_mode2;
  logic [7:0] next_cmp0;
  logic [7:0] next_cmp1;
  logic [7:0] next_cmp2;
  logic [7:0] next_cpu_rdata;
  logic any_wr;

  logic [WIDTH-1:0] cnt0;
  logic [WIDTH-1:0] cnt1;
  logic [WIDTH-1:0] cnt2;
  logic [2:0] match;
  logic [2:0] toggle;

  assign any_wr = cpu_byte_wr | cpu_bit_wr;

  always_comb begin
    next_port3_direction = port3_direction;
    next_port3_latch = port3_latch;
    next_mode0 = mode0;
    next_mode1 = mode1;
    next_mode2 = mode2;
    next_cmp0 = cmp0;
    next_cmp1 = cmp1;
    next_cmp2 = cmp2;
    if (any_wr && cpu_addr == eit_pkg::ADDR_PORT3_DIRECTION) begin
      next_port3_direction = apply_write(port3_direction, cpu_byte_wr, cpu_bit_wr, cpu_bit_sel, cpu_bit_val,
                                         cpu_wdata, 8'hff) | eit_pkg::DIR_FIXED_ONES;
    end else if (any_wr && cpu_addr == eit_pkg::ADDR_PORT3_LATCH) begin
      next_port3_latch = apply_write(port3_latch, cpu_byte_wr, cpu_bit_wr, cpu_bit_sel, cpu_bit_val,
                                     cpu_wdata, eit_pkg::LATCH_WMASK);
    end else if (any_wr && cpu_addr == eit_pkg::ADDR_MODE0) begin
      next_mode0 = apply_write(mode0, cpu_byte_wr, cpu_bit_wr, cpu_bit_sel, cpu_bit_val,
                               cpu_wdata, eit_pkg::MODE0_WMASK);
    end else if (any_wr && cpu_addr == eit_pkg::ADDR_MODE1) begin
      next_mode1 = apply_write(mode1, cpu_byte_wr, cpu_bit_wr, cpu_bit_sel, cpu_bit_val,
                               cpu_wdata, eit_pkg::MODE12_WMASK);
    end else if (any_wr && cpu_addr == eit_pkg::ADDR_MODE2) begin
      next_mode2 = apply_write(mode2, cpu_byte_wr, cpu_bit_wr, cpu_bit_sel, cpu_bit_val,
                               cpu_wdata, eit_pkg::MODE12_WMASK);
    end else if (any_wr && cpu_addr == eit_pkg::ADDR_CMP0) begin
      next_cmp0 = apply_write(cmp0, cpu_byte_wr, cpu_bit_wr, cpu_bit_sel, cpu_bit_val, cpu_wdata, 8'hff);
    end else if (any_wr && cpu_addr == eit_pkg::ADDR_CMP1) begin
      next_cmp1 = apply_write(cmp1, cpu_byte_wr, cpu_bit_wr, cpu_bit_sel, cpu_bit_val, cpu_wdata, 8'hff);
    end else if (any_wr && cpu_addr == eit_pkg::ADDR_CMP2) begin
      next_cmp2 = apply_write(cmp2, cpu_byte_wr, cpu_bit_wr, cpu_bit_sel, cpu_bit_val, cpu_wdata, 8'hff);
    end
  end

  // Read mux, answer registered one cycle after the strobe
  always_comb begin
    next_cpu_rdata = cpu_rdata;
    if (cpu_rd) begin
      if (cpu_addr == eit_pkg::ADDR_PORT3_DIRECTION) begin
        next_cpu_rdata = port3_direction | eit_pkg::DIR_FIXED_ONES;
      end else if (cpu_addr == eit_pkg::ADDR_PORT3_LATCH) begin
        next_cpu_rdata = port3_latch;
      end else if (cpu_addr == eit_pkg::ADDR_MODE0) begin
        next_cpu_rdata = mode0;
      end else if (cpu_addr == eit_pkg::ADDR_MODE1) begin
        next_cpu_rdata = mode1;
      end else if (cpu_addr == eit_pkg::ADDR_MODE2) begin
        next_cpu_rdata = mode2;
      end else if (cpu_addr == eit_pkg::ADDR_CMP0) begin
        next_cpu_rdata = cmp0;
      end else if (cpu_addr == eit_pkg::ADDR_CMP1) begin
        next_cpu_rdata = cmp1;
      end else if (cpu_addr == eit_pkg::ADDR_CMP2) begin
        next_cpu_rdata = cmp2;
      end else if (cpu_addr == eit_pkg::ADDR_CNT0) begin
        next_cpu_rdata = cnt0;
      end else if (cpu_addr == eit_pkg::ADDR_CNT1) begin
        next_cpu_rdata = cnt1;
      end else if (cpu_addr == eit_pkg::ADDR_CNT2) begin
        next_cpu_rdata = cnt2;
      end else begin
        next_cpu_rdata = eit_pkg::RST_READ;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      port3_direction <= eit_pkg::RST_PORT3_DIRECTION;
      port3_latch <= eit_pkg::RST_PORT3_LATCH;
      mode0 <= eit_pkg::RST_MODE;
      mode1 <= eit_pkg::RST_MODE;
      mode2 <= eit_pkg::RST_MODE;
      cmp0 <= eit_pkg::RST_CMP;
      cmp1 <= eit_pkg::RST_CMP;
      cmp2 <= eit_pkg::RST_CMP;
      cpu_rdata <= eit_pkg::RST_READ;
    end else begin
      port3_direction <= next_port3_direction;
      port3_latch <= next_port3_latch;
      mode0 <= next_mode0;
      mode1 <= next_mode1;
      mode2 <= next_mode2;
      cmp0 <= next_cmp0;
      cmp1 <= next_cmp1;
      cmp2 <= next_cmp2;
      cpu_rdata <= next_cpu_rdata;
    end
  end

  // ==========================================================
  // Input synchronisers: bit0 pin0, bit1 pin2, bit2 subsystem clock
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] filt;
  logic [2:0] rise;
  logic [2:0] next_filt;
  logic [2:0] next_rise;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
    end
    next_rise = next_filt & ~filt;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      filt <= 3'h0;
      rise <= 3'h0;
    end else begin
      sync1 <= {sub_clk, p3_in[2], p3_in[0]};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      rise <= next_rise;
    end
  end

  // ==========================================================
  // Prescaler and pin-edge dividers
  logic [6:0] presc;
  logic [6:0] pdiv1;
  logic [6:0] pdiv2;
  logic [6:0] next_presc;
  logic [6:0] next_pdiv1;
  logic [6:0] next_pdiv2;
  logic [2:0] run;

  function automatic logic is_running(input logic [7:0] mode);
    return mode[eit_pkg::BIT_TCE] && mode[eit_pkg::BIT_MODE_HI:eit_pkg::BIT_MODE_LO] == eit_pkg::MODE_STANDALONE;
  endfunction

  assign run[0] = is_running(mode0);
  assign run[1] = is_running(mode1);
  assign run[2] = is_running(mode2);

  always_comb begin
    next_presc = 7'(presc + 7'h01);
    next_pdiv1 = pdiv1;
    next_pdiv2 = pdiv2;
    if (!run[1]) begin
      next_pdiv1 = 7'h00;
    end else if (rise[0]) begin
      next_pdiv1 = {4'h0, 3'(pdiv1[2:0] + 3'h1)};
    end
    if (!run[2]) begin
      next_pdiv2 = 7'h00;
    end else if (rise[1]) begin
      next_pdiv2 = {4'h0, 3'(pdiv2[2:0] + 3'h1)};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      presc <= 7'h00;
      pdiv1 <= 7'h00;
      pdiv2 <= 7'h00;
    end else begin
      presc <= next_presc;
      pdiv1 <= next_pdiv1;
      pdiv2 <= next_pdiv2;
    end
  end

  // ==========================================================
  // Count clock selection
  logic [2:0] tick;

  always_comb begin
    case (mode0[eit_pkg::BIT_CLK_HI:eit_pkg::BIT_CLK_LO])
      eit_pkg::SEL_MAIN: tick[0] = 1'b1;
      eit_pkg::SEL_MAIN_DIV: tick[0] = div_tick(presc, eit_pkg::MASK_DIV8);
      eit_pkg::SEL_T0_DIV128: tick[0] = div_tick(presc, eit_pkg::MASK_DIV128);
      eit_pkg::SEL_T0_SUB: tick[0] = rise[2];
      eit_pkg::SEL_T0_T1_MATCH: tick[0] = match[1];
      eit_pkg::SEL_T0_T1_OUT: tick[0] = match[1] & toggle[1];
      default: tick[0] = 1'b0;
    endcase
    case (mode1[eit_pkg::BIT_CLK_HI:eit_pkg::BIT_CLK_LO])
      eit_pkg::SEL_MAIN: tick[1] = 1'b1;
      eit_pkg::SEL_MAIN_DIV: tick[1] = div_tick(presc, eit_pkg::MASK_DIV4);
      eit_pkg::SEL_PIN_DIV1: tick[1] = rise[0] & div_tick(pdiv1, eit_pkg::MASK_DIV1);
      eit_pkg::SEL_PIN_DIV2: tick[1] = rise[0] & div_tick(pdiv1, eit_pkg::MASK_DIV2);
      eit_pkg::SEL_PIN_DIV4: tick[1] = rise[0] & div_tick(pdiv1, eit_pkg::MASK_DIV4);
      eit_pkg::SEL_PIN_DIV8: tick[1] = rise[0] & div_tick(pdiv1, eit_pkg::MASK_DIV8);
      default: tick[1] = 1'b0;
    endcase
    case (mode2[eit_pkg::BIT_CLK_HI:eit_pkg::BIT_CLK_LO])
      eit_pkg::SEL_MAIN: tick[2] = 1'b1;
      eit_pkg::SEL_MAIN_DIV: tick[2] = div_tick(presc, eit_pkg::MASK_DIV16);
      eit_pkg::SEL_PIN_DIV1: tick[2] = rise[1] & div_tick(pdiv2, eit_pkg::MASK_DIV1);
      eit_pkg::SEL_PIN_DIV2: tick[2] = rise[1] & div_tick(pdiv2, eit_pkg::MASK_DIV2);
      eit_pkg::SEL_PIN_DIV4: tick[2] = rise[1] & div_tick(pdiv2, eit_pkg::MASK_DIV4);
      eit_pkg::SEL_PIN_DIV8: tick[2] = rise[1] & div_tick(pdiv2, eit_pkg::MASK_DIV8);
      default: tick[2] = 1'b0;
    endcase
  end

  // ==========================================================
  // Timer channels
  eit_timer8 #(.WIDTH(WIDTH)) u_timer0 (.mclk(mclk), .reset_n(reset_n), .run(run[0]), .tick(tick[0]),
    .compare(cmp0[WIDTH-1:0]), .count(cnt0), .match(match[0]), .toggle(toggle[0]));

  eit_timer8 #(.WIDTH(WIDTH)) u_timer1 (.mclk(mclk), .reset_n(reset_n), .run(run[1]), .tick(tick[1]),
    .compare(cmp1[WIDTH-1:0]), .count(cnt1), .match(match[1]), .toggle(toggle[1]));

  eit_timer8 #(.WIDTH(WIDTH)) u_timer2 (.mclk(mclk), .reset_n(reset_n), .run(run[2]), .tick(tick[2]),
    .compare(cmp2[WIDTH-1:0]), .count(cnt2), .match(match[2]), .toggle(toggle[2]));

  assign match_interrupt_request = match;

  // ==========================================================
  // Port-3 pins
  logic [2:0] next_p3_out;
  logic [2:0] toe;

  assign toe = {mode2[eit_pkg::BIT_TOE], mode1[eit_pkg::BIT_TOE], mode0[eit_pkg::BIT_TOE]};
  assign p3_oe = ~port3_direction[2:0];

  always_comb begin
    next_p3_out = port3_latch[2:0] | (toe & toggle);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      p3_out <= 3'h0;
    end else begin
      p3_out <= next_p3_out;
    end
  end

endmodule

// File: include/eit_pkg.sv
// Shared constants for the three-channel 8-bit interval and event timer
package eit_pkg;

  // ==========================================================
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ==========================================================
  // Register addresses
  localparam logic [15:0] ADDR_PORT3_DIRECTION = 16'hff23;
  localparam logic [15:0] ADDR_PORT3_LATCH = 16'hff03;
  localparam logic [15:0] ADDR_MODE0 = 16'hff4d;
  localparam logic [15:0] ADDR_MODE1 = 16'hff4e;
  localparam logic [15:0] ADDR_MODE2 = 16'hff41;
  localparam logic [15:0] ADDR_CMP0 = 16'hff48;
  localparam logic [15:0] ADDR_CMP1 = 16'hff49;
  localparam logic [15:0] ADDR_CMP2 = 16'hff4a;
  localparam logic [15:0] ADDR_CNT0 = 16'hff44;
  localparam logic [15:0] ADDR_CNT1 = 16'hff45;
  localparam logic [15:0] ADDR_CNT2 = 16'hff46;

  // ==========================================================
  // Reset values and fixed bits
  localparam logic [7:0] RST_PORT3_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PORT3_LATCH = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [7:0] RST_READ = 8'h00;
  localparam logic [7:0] DIR_FIXED_ONES = 8'he0;
  localparam logic [7:0] LATCH_WMASK = 8'h1f;
  localparam logic [7:0] MODE0_WMASK = 8'hff;
  localparam logic [7:0] MODE12_WMASK = 8'hbf;

  // ==========================================================
  // Mode register field positions
  localparam int BIT_TCE = 7;
  localparam int BIT_EDGE = 6;
  localparam int BIT_CLK_HI = 5;
  localparam int BIT_CLK_LO = 3;
  localparam int BIT_MODE_HI = 2;
  localparam int BIT_MODE_LO = 1;
  localparam int BIT_TOE = 0;
  localparam logic [1:0] MODE_STANDALONE = 2'h0;

  // ==========================================================
  // Count clock select codes
  localparam logic [2:0] SEL_MAIN = 3'h0;
  localparam logic [2:0] SEL_MAIN_DIV = 3'h1;
  localparam logic [2:0] SEL_T0_DIV128 = 3'h2;
  localparam logic [2:0] SEL_T0_SUB = 3'h3;
  localparam logic [2:0] SEL_T0_T1_MATCH = 3'h4;
  localparam logic [2:0] SEL_T0_T1_OUT = 3'h5;
  localparam logic [2:0] SEL_PIN_DIV1 = 3'h2;
  localparam logic [2:0] SEL_PIN_DIV2 = 3'h3;
  localparam logic [2:0] SEL_PIN_DIV4 = 3'h4;
  localparam logic [2:0] SEL_PIN_DIV8 = 3'h5;

  // ==========================================================
  // Divider masks (divide by mask plus one)
  localparam int PRESC_W = 7;
  localparam logic [6:0] MASK_DIV1 = 7'h00;
  localparam logic [6:0] MASK_DIV2 = 7'h01;
  localparam logic [6:0] MASK_DIV4 = 7'h03;
  localparam logic [6:0] MASK_DIV8 = 7'h07;
  localparam logic [6:0] MASK_DIV16 = 7'h0f;
  localparam logic [6:0] MASK_DIV128 = 7'h7f;

  // ==========================================================
  // Clock
  localparam int MCLK_PERIOD_NS = 10;

endpackage

// File: rtl/eit_timer8.sv
// One 8-bit up-counter with compare-match clear and match pulse
`timescale 1ns/1ps
module eit_timer8 #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [WIDTH-1:0] compare,
  output logic [WIDTH-1:0] count,
  output logic match,
  output logic toggle
);

  logic [WIDTH-1:0] next_count;
  logic next_match;
  logic next_toggle;

  // ==========================================================
  // Counter
  always_comb begin
    next_count = count;
    next_match = 1'b0;
    next_toggle = toggle;
    if (!run) begin
      next_count = '0;
      next_toggle = 1'b0;
    end else if (tick) begin
      if (count == compare) begin
        next_count = '0;
        next_match = 1'b1;
        next_toggle = ~toggle;
      end else begin
        next_count = WIDTH'(count + 1'b1);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      match <= 1'b0;
      toggle <= 1'b0;
    end else begin
      count <= next_count;
      match <= next_match;
      toggle <= next_toggle;
    end
  end

endmodule

// File: testbench/eit_pulse_source.sv
// Pulse source driving the timer clock input pins
`timescale 1ns/1ps
module eit_pulse_source (
  output logic [2:0] p3_in
);
  // ==========================================
  // Pulse generation
  initial p3_in = 3'h0;
  // Each level lasts half ns, wide enough for the input synchroniser
  task automatic send(input int ch, input int n, input int half);
    for (int k = 0; k < n; k++) begin
      #(half) p3_in[ch] = 1'b1;
      #(half) p3_in[ch] = 1'b0;
    end
  endtask
endmodule

// File: testbench/eit_timer_assertions.sv
// Port-level checks for the timer block
`timescale 1ns/1ps
module eit_timer_assertions #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_byte_wr,
  input wire logic cpu_bit_wr,
  input wire logic [2:0] cpu_bit_sel,
  input wire logic cpu_bit_val,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_rdata,
  input wire logic sub_clk,
  input wire logic [2:0] p3_in,
  input wire logic [2:0] p3_out,
  input wire logic [2:0] p3_oe,
  input wire logic [2:0] match_interrupt_request
);
  // ==========================================
  // Shadow of mode and compare registers
  localparam logic [15:0] MADR [3] = '{eit_pkg::ADDR_MODE0, eit_pkg::ADDR_MODE1, eit_pkg::ADDR_MODE2};
  localparam logic [15:0] CADR [3] = '{eit_pkg::ADDR_CMP0, eit_pkg::ADDR_CMP1, eit_pkg::ADDR_CMP2};
  logic [7:0] mode_q [3];
  logic [7:0] cmp_q [3];
  logic [2:0] run_q;
  logic [8:0] gap;
  logic seen;
  logic wr_any;
  logic dwr;
  function automatic logic [7:0] upd(input logic [7:0] old);
    upd = old;
    if (cpu_byte_wr) upd = cpu_wdata;
    else if (cpu_bit_wr) upd[cpu_bit_sel] = cpu_bit_val;
  endfunction
  assign wr_any = cpu_byte_wr || cpu_bit_wr;
  assign dwr = wr_any && cpu_addr == eit_pkg::ADDR_PORT3_DIRECTION;
  always_comb begin
    for (int i = 0; i < 3; i++) run_q[i] = mode_q[i][7] && mode_q[i][2:1] == 2'h0;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= '{default: 8'h00};
      cmp_q <= '{default: 8'h00};
      gap <= 9'h000;
      seen <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cpu_addr == MADR[i]) mode_q[i] <= upd(mode_q[i]);
        if (cpu_addr == CADR[i]) cmp_q[i] <= upd(cmp_q[i]);
      end
      gap <= match_interrupt_request[1] ? 9'h001 : gap + 9'h001;
      seen <= run_q[1] && mode_q[1][5:3] == 3'h0 && !wr_any && (match_interrupt_request[1] || seen);
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_oe_only_write: assert property ($changed(p3_oe) |-> $past(dwr))
    else $error("pin enable moved without a write");
  chk_oe_byte_wr: assert property (dwr && cpu_byte_wr |=> p3_oe == ~$past(cpu_wdata[2:0]))
    else $error("pin enable differs from byte write");
  chk_oe_bit_wr: assert property (dwr && !cpu_byte_wr && cpu_bit_sel < 3'h3 |=>
    p3_oe[$past(cpu_bit_sel)] == !$past(cpu_bit_val)) else $error("pin enable differs from bit write");
  chk_dir_read_ones: assert property (cpu_rd && cpu_addr == eit_pkg::ADDR_PORT3_DIRECTION |=>
    cpu_rdata[7:5] == 3'h7 && cpu_rdata[2:0] == ~$past(p3_oe)) else $error("direction read wrong");
  chk_irq_needs_run: assert property ((match_interrupt_request & ~$past(run_q)) == 3'h0)
    else $error("interrupt from a stopped timer");
  chk_cmp_zero_every: assert property ($rose(run_q[0]) && cmp_q[0] == 8'h00 && mode_q[0][5:3] == 3'h0
    |=> match_interrupt_request[0] [*3]) else $error("compare zero missed a tick");
  chk_match_period: assert property (match_interrupt_request[1] && seen |->
    gap == {1'b0, cmp_q[1]} + 9'h001) else $error("match period wrong");
  chk_cnt_zero_irq: assert property (cpu_rd && cpu_addr == eit_pkg::ADDR_CNT1 && match_interrupt_request[1]
    |=> cpu_rdata == 8'h00) else $error("counter not cleared on match");
  chk_stopped_zero: assert property (cpu_rd && cpu_addr == eit_pkg::ADDR_CNT2 && !run_q[2] &&
    !$past(run_q[2]) |=> cpu_rdata == 8'h00) else $error("stopped counter not zero");
  cov_start: cover property ($rose(run_q[1]));
  cov_event_irq: cover property (match_interrupt_request[2]);
  cov_bit_wr: cover property (dwr && cpu_bit_wr);
endmodule

// File: testbench/eit_timer_top_test.sv
// Self-checking bench for the three-channel timer block
`timescale 1ns/1ps
module eit_timer_top_test;
  localparam logic [15:0] DIR = eit_pkg::ADDR_PORT3_DIRECTION;
  localparam logic [15:0] MA [3] = '{eit_pkg::ADDR_MODE0, eit_pkg::ADDR_MODE1, eit_pkg::ADDR_MODE2};
  localparam logic [15:0] CA [3] = '{eit_pkg::ADDR_CMP0, eit_pkg::ADDR_CMP1, eit_pkg::ADDR_CMP2};
  localparam logic [15:0] NA [3] = '{eit_pkg::ADDR_CNT0, eit_pkg::ADDR_CNT1, eit_pkg::ADDR_CNT2};
  logic mclk, reset_n, cpu_byte_wr, cpu_bit_wr, cpu_bit_val, cpu_rd, sub_clk;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, rd_val;
  logic [2:0] cpu_bit_sel, p3_in, p3_out, p3_oe, irq;
  int fails, tests_run;
  int irq_cnt [3];
  eit_timer_top u_dut (.mclk(mclk), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_byte_wr(cpu_byte_wr), .cpu_bit_wr(cpu_bit_wr), .cpu_bit_sel(cpu_bit_sel),
    .cpu_bit_val(cpu_bit_val), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .sub_clk(sub_clk),
    .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe), .match_interrupt_request(irq));
  eit_pulse_source u_src (.p3_in(p3_in));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    sub_clk = 1'b0;
    #3;
    forever #40 sub_clk = ~sub_clk;
  end
  always @(posedge mclk) begin
    for (int i = 0; i < 3; i++) if (irq[i] === 1'b1) irq_cnt[i]++;
  end
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_byte_wr = 1'b1;
    @(negedge mclk);
    cpu_byte_wr = 1'b0;
  endtask
  task automatic bitwr(input logic [2:0] s, input logic v);
    @(negedge mclk);
    cpu_addr = DIR;
    cpu_bit_sel = s;
    cpu_bit_val = v;
    cpu_bit_wr = 1'b1;
    @(negedge mclk);
    cpu_bit_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge mclk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge mclk);
    cpu_rd = 1'b0;
    rd_val = cpu_rdata;
  endtask
  task automatic start(input int i, input logic [2:0] sel, input logic [7:0] c);
    wr(MA[i], 8'h00);
    wr(CA[i], c);
    wr(MA[i], {2'h0, sel, 3'h0});
    wr(MA[i], {2'h2, sel, 3'h0});
  endtask
  // Measures the gap between two later match pulses, reading the second counter meanwhile
  task automatic run_case(input int i, input logic [2:0] sel, input logic [7:0] c, input int exp);
    int n;
    start(i, sel, c);
    cpu_addr = NA[1];
    cpu_rd = 1'b1;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (irq[i] !== 1'b1 && n < 3000);
    end
    cpu_rd = 1'b0;
    check(n, exp);
    if (n >= 3000) print_verdict();
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    check(p3_oe, 3'h0);
    check(irq, 3'h0);
    rd(DIR);
    check(rd_val, 8'hff);
    rd(16'h0000);
    check(rd_val, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rd(MA[i]);
      check(rd_val, eit_pkg::RST_MODE);
      rd(NA[i]);
      check(rd_val, 8'h00);
    end
    $display("test reset done");
  endtask
  task automatic t_dir();
    wr(DIR, 8'h00);
    check(p3_oe, 3'h7);
    rd(DIR);
    check(rd_val, 8'he0);
    bitwr(3'h1, 1'b1);
    check(p3_oe, 3'h5);
    bitwr(3'h6, 1'b0);
    rd(DIR);
    check(rd_val, 8'he2);
    wr(DIR, 8'h1a);
    check(p3_oe, 3'h5);
    rd(DIR);
    check(rd_val, 8'hfa);
    $display("test direction done");
  endtask
  task automatic t_interval();
    run_case(0, 3'h0, 8'h00, 1);
    run_case(1, 3'h0, 8'hff, 256);
    run_case(1, 3'h1, 8'h02, 12);
    run_case(2, 3'h1, 8'h00, 16);
    run_case(0, 3'h1, 8'h01, 16);
    run_case(0, 3'h2, 8'h00, 128);
    run_case(0, 3'h3, 8'h01, 16);
    run_case(1, 3'h0, 8'h01, 2);
    run_case(0, 3'h4, 8'h02, 6);
    run_case(0, 3'h5, 8'h01, 8);
    $display("test interval done");
  endtask
  task automatic t_event();
    int pin;
    wr(DIR, 8'hff);
    for (int ch = 1; ch < 3; ch++) begin
      pin = (ch == 1) ? 0 : 2;
      for (int d = 0; d < 4; d++) begin
        start(ch, 3'(2 + d), 8'h01);
        irq_cnt[ch] = 0;
        u_src.send(pin, 2 << d, 40);
        repeat (8) @(negedge mclk);
        check(irq_cnt[ch], 1);
        u_src.send(pin, 1 << d, 30);
        repeat (8) @(negedge mclk);
        rd(NA[ch]);
        check(rd_val, 8'h01);
      end
    end
    $display("test event done");
  endtask
  task automatic t_pin();
    int n;
    bitwr(3'h1, 1'b0);
    check(p3_oe, 3'h2);
    wr(eit_pkg::ADDR_PORT3_LATCH, 8'hff);
    rd(eit_pkg::ADDR_PORT3_LATCH);
    check(rd_val, 8'h1f);
    check(p3_out, 3'h7);
    wr(eit_pkg::ADDR_PORT3_LATCH, 8'h00);
    start(1, 3'h0, 8'h04);
    wr(MA[1], 8'h81);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (irq[1] !== 1'b1 && n < 100);
      @(negedge mclk);
      check(n < 100, 1'b1);
      check(p3_out, (k == 0) ? 3'h2 : 3'h0);
    end
    $display("test pin done");
  endtask
  task automatic t_stop();
    start(1, 3'h0, 8'h03);
    start(2, 3'h0, 8'h00);
    wr(MA[1], 8'h00);
    @(negedge mclk);
    irq_cnt = '{0, 0, 0};
    repeat (20) @(negedge mclk);
    check(irq_cnt[1], 0);
    check(irq_cnt[2], 20);
    rd(NA[1]);
    check(rd_val, 8'h00);
    wr(MA[2], 8'h82);
    @(negedge mclk);
    irq_cnt[2] = 0;
    repeat (10) @(negedge mclk);
    check(irq_cnt[2], 0);
    rd(NA[2]);
    check(rd_val, 8'h00);
    start(2, 3'h6, 8'h00);
    irq_cnt[2] = 0;
    repeat (10) @(negedge mclk);
    check(irq_cnt[2], 0);
    $display("test stop done");
  endtask
  initial begin
    {reset_n, cpu_byte_wr, cpu_bit_wr, cpu_bit_val, cpu_rd} = 5'h00;
    {cpu_addr, cpu_wdata, cpu_bit_sel} = 27'h0;
    fails = 0;
    tests_run = 0;
    irq_cnt = '{0, 0, 0};
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    t_reset();
    t_dir();
    t_interval();
    t_event();
    t_pin();
    t_stop();
    print_verdict();
  end
  initial begin
    #900us;
    fails++;
    print_verdict();
  end
endmodule
bind eit_timer_top eit_timer_assertions #(.WIDTH(WIDTH)) u_chk (.mclk(mclk), .reset_n(reset_n),
  .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_byte_wr(cpu_byte_wr), .cpu_bit_wr(cpu_bit_wr),
  .cpu_bit_sel(cpu_bit_sel), .cpu_bit_val(cpu_bit_val), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
  .sub_clk(sub_clk), .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe),
  .match_interrupt_request(match_interrupt_request));
